// file: testbench/testbench.sv
// Self-checking bench for the control word block
`timescale 1ns/1ps
module testbench;
	import tsbmc_pkg::*;
	logic mclk, sys_rst, software_reset_cmd, broadcast_disable, terminal_enable;
	logic buf_sel, buf_sel_valid, illegal_cmd, illegal_respond, rd_q, illegal_detect_en;
	logic [15:0] host_rdata, lfsr, d;
	logic [3:0] circ2_trailing_zero_count;
	tsbmc_cmd_t cmd;
	tsbmc_done_t done;
	tsbmc_host_t host;
	tsbmc_mode_t buf_mode;
	logic [15:0] word_q[$];
	logic [3:0] sel_q[$];
	int n_errors = 0;
	int check_count = 0;
	tsbmc_ctrl tsbmc_ctrl_inst (.mclk(mclk), .sys_rst(sys_rst),
		.software_reset_cmd(software_reset_cmd), .broadcast_disable(broadcast_disable),
		.illegal_detect_en(illegal_detect_en), .terminal_enable(terminal_enable), .cmd(cmd),
		.done(done),
		.host(host), .host_rdata(host_rdata), .buf_mode(buf_mode), .buf_sel(buf_sel),
		.buf_sel_valid(buf_sel_valid), .circ2_trailing_zero_count(circ2_trailing_zero_count),
		.illegal_cmd(illegal_cmd), .illegal_respond(illegal_respond));
	tsbmc_host_model host_model (.mclk(mclk), .host(host));
	initial
	begin
		mclk = 0;
		forever #10 mclk = ~mclk;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		n_errors += word_q.size() + sel_q.size();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic send(input logic b, input logic [3:0] e);
		if (e != 4'h0 || !b)
			sel_q.push_back(e);
		@(posedge mclk);
		cmd <= '{valid: 1'b1, broadcast: b};
		@(posedge mclk);
		cmd <= '0;
	endtask
	task automatic finish_msg();
		@(posedge mclk);
		done <= '{valid: 1'b1, error_free: 1'b1};
		@(posedge mclk);
		done <= '0;
	endtask
	task automatic read_exp(input logic [15:0] e);
		word_q.push_back(e);
		host_model.rd();
	endtask
	// Outputs are compared against the oldest note when they appear
	always @(posedge mclk)
	begin
		rd_q <= host.rd;
		if (rd_q)
			check("word", host_rdata, word_q.size() ? word_q.pop_front() : 16'hFFFF);
		if (buf_sel_valid)
			check("sel", {illegal_cmd, buf_mode, buf_sel}, sel_q.size() ? sel_q.pop_front() : 16'hFFFF);
	end
	initial
	begin
		#200000;
		n_errors++;
		end_sim();
	end
	initial
	begin
		sys_rst = 1;
		{software_reset_cmd, broadcast_disable, rd_q, illegal_detect_en} = '0;
		terminal_enable = 1;
		cmd = '0;
		done = '0;
		lfsr = 16'h0016;
		repeat (8) @(posedge mclk);
		sys_rst <= 0;
		read_exp(16'h0000);
		host_model.wr(16'h00F4);
		send(0, {1'b0, TSBMC_PINGPONG, 1'b0});
		finish_msg();
		read_exp(16'h05F4);
		host_model.wr(16'h0DFC);
		send(0, {1'b0, TSBMC_PINGPONG, 1'b1});
		finish_msg();
		read_exp(16'h04FC);
		host_model.wr(16'h00F4);
		send(0, {1'b0, TSBMC_PINGPONG, 1'b1});
		read_exp(16'h05F4);
		@(posedge mclk);
		broadcast_disable <= 1;
		send(1, 4'h0);
		read_exp(16'h05F4);
		broadcast_disable <= 0;
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		illegal_detect_en <= lfsr[0];
		send(1, {1'b1, TSBMC_PINGPONG, 1'b1});
		read_exp(16'h07F4);
		check("respond", {15'h0000, illegal_respond}, {15'h0000, lfsr[0]});
		@(posedge mclk);
		software_reset_cmd <= 1;
		@(posedge mclk);
		software_reset_cmd <= 0;
		read_exp(16'h01F4);
		for (int i = 0; i < 4; i++)
		begin
			lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			d = {lfsr[15:12], 4'h0, lfsr[7:4], 2'b00, i[1:0]};
			host_model.wr(d);
			// The write lands at the edge the task returns on; look once it has settled
			@(negedge mclk);
			check("zero count", circ2_trailing_zero_count, lfsr[7:4]);
			send(0, {1'b0, i[1] ? TSBMC_CIRC2 : i[0] ? TSBMC_CIRC1 : TSBMC_INDEXED, 1'b0});
			read_exp(d);
		end
		repeat (3) @(posedge mclk);
		end_sim();
	end
endmodule

// file: testbench/tsbmc_host_model.sv
// Host model: writes and reads the control word
`timescale 1ns/1ps
module tsbmc_host_model
(
	// Clock
	input wire logic mclk,
	// Host request
	output tsbmc_pkg::tsbmc_host_t host
);
	import tsbmc_pkg::*;
	initial host = '0;
	// Device bits 11-8 are never written
	task automatic wr(input logic [15:0] d);
		@(posedge mclk);
		host <= '{wr: 1'b1, rd: 1'b0, wdata: d & HOST_WR_MASK};
		@(posedge mclk);
		host <= '0;
	endtask
	task automatic rd();
		@(posedge mclk);
		host <= '{wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
		@(posedge mclk);
		host <= '0;
	endtask
endmodule

// file: verilog/tsbmc_ctrl.sv
// Transmit subaddress control word: broadcast flag, ping-pong handshake, mode decode
`timescale 1ns/1ps
module tsbmc_ctrl
(
	// Clock and resets
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic software_reset_cmd,
	// Terminal configuration
	input wire logic broadcast_disable,
	input wire logic illegal_detect_en,
	input wire logic terminal_enable,
	// Message processor events
	input wire tsbmc_pkg::tsbmc_cmd_t cmd,
	input wire tsbmc_pkg::tsbmc_done_t done,
	// Host access to the control word
	input wire tsbmc_pkg::tsbmc_host_t host,
	output logic [15:0] host_rdata,
	// Buffer selection for the message processor
	output tsbmc_pkg::tsbmc_mode_t buf_mode,
	output logic buf_sel,
	output logic buf_sel_valid,
	output logic [3:0] circ2_trailing_zero_count,
	// Illegal broadcast indication
	output logic illegal_cmd,
	output logic illegal_respond
);
	import tsbmc_pkg::*;

	typedef struct packed {
		logic [15:0] cw;
		logic [15:0] rdata;
		tsbmc_mode_t mode;
		logic sel;
		logic sel_valid;
		logic live;
		logic illegal;
		logic illegal_resp;
	} tsbmc_state_t;

	tsbmc_state_t st_q;
	tsbmc_state_t st_d;
	logic accept;
	logic ack_next;

	// Address 31 commands are not valid while broadcast is disabled
	assign accept = cmd.valid && !(cmd.broadcast && broadcast_disable);

	always_comb
	begin
		st_d = st_q;
		ack_next = st_q.cw[BIT_ACK];
		st_d.sel_valid = 1'b0;
		st_d.illegal = 1'b0;
		if (host.wr)
		begin
			// Device-owned bits keep their own value whatever the host writes
			st_d.cw = (host.wdata & HOST_WR_MASK) | (st_q.cw & ~HOST_WR_MASK);
		end
		if (host.rd)
			st_d.rdata = st_q.cw;
		if (accept)
		begin
			// Stop request is sampled here, before the buffer is chosen
			if (!st_q.cw[BIT_PINGPONG_ENABLE])
				ack_next = 1'b0;
			else if (st_q.cw[BIT_STOP])
				ack_next = 1'b0;
			else if (terminal_enable)
				ack_next = 1'b1;
			st_d.cw[BIT_ACK] = ack_next;
			st_d.mode = tsbmc_decode(st_q.cw[BIT_PINGPONG_ENABLE:BIT_CIR1]);
			st_d.sel = st_q.cw[BIT_PTR];
			st_d.sel_valid = 1'b1;
			st_d.live = st_q.cw[BIT_PINGPONG_ENABLE] && ack_next;
			if (cmd.broadcast)
			begin
				// Non-mode broadcast transmit is always illegal
				st_d.cw[BIT_BROADCAST_RECEIVED_FLAG] = 1'b1;
				st_d.illegal = 1'b1;
				st_d.illegal_resp = illegal_detect_en;
			end
		end
		if (done.valid)
		begin
			// A stopped ping-pong keeps reusing the same buffer
			if (st_q.live && done.error_free)
				st_d.cw[BIT_PTR] = ~st_q.cw[BIT_PTR];
			st_d.live = 1'b0;
		end
		if (software_reset_cmd)
		begin
			st_d.cw[BIT_BROADCAST_RECEIVED_FLAG] = 1'b0;
			st_d.cw[BIT_PTR] = 1'b0;
			st_d.live = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_q.cw <= CW_RESET;
			st_q.rdata <= 16'h0000;
			st_q.mode <= TSBMC_INDEXED;
			st_q.sel <= 1'b0;
			st_q.sel_valid <= 1'b0;
			st_q.live <= 1'b0;
			st_q.illegal <= 1'b0;
			st_q.illegal_resp <= 1'b0;
		end
		else
			st_q <= st_d;
	end

	assign host_rdata = st_q.rdata;
	assign buf_mode = st_q.mode;
	assign buf_sel = st_q.sel;
	assign buf_sel_valid = st_q.sel_valid;
	// Only meaningful in circular mode 2; the host loads it
	assign circ2_trailing_zero_count = st_q.cw[ZN_MSB:ZN_LSB];
	assign illegal_cmd = st_q.illegal;
	assign illegal_respond = st_q.illegal_resp;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	sequence s_broadcast_received_flag_cmd;
		accept && cmd.broadcast && !software_reset_cmd;
	endsequence

	sequence s_pp_resume;
		accept && st_q.cw[BIT_PINGPONG_ENABLE] && !st_q.cw[BIT_STOP] && terminal_enable;
	endsequence

	chk_broadcast_received_flag_set: assert property (s_broadcast_received_flag_cmd |=> st_q.cw[BIT_BROADCAST_RECEIVED_FLAG])
		else $error("broadcast flag not set");
	chk_broadcast_received_flag_illegal: assert property (s_broadcast_received_flag_cmd |=>
		illegal_cmd && (illegal_respond == $past(illegal_detect_en)))
		else $error("illegal broadcast not signalled");
	chk_broadcast_received_flag_ignored: assert property (cmd.valid && cmd.broadcast && broadcast_disable
		|=> !buf_sel_valid && !illegal_cmd)
		else $error("disabled broadcast accepted");
	chk_swrst_clear: assert property (software_reset_cmd
		|=> !st_q.cw[BIT_BROADCAST_RECEIVED_FLAG] && !st_q.cw[BIT_PTR])
		else $error("software reset left flag set");
	chk_ack_resume: assert property (s_pp_resume |=> st_q.cw[BIT_ACK] && buf_sel_valid)
		else $error("acknowledge not set");
	chk_ack_needs_en: assert property (accept && !st_q.cw[BIT_PINGPONG_ENABLE] |=> !st_q.cw[BIT_ACK])
		else $error("acknowledge without enable");
	chk_stop_clear: assert property (accept && st_q.cw[BIT_STOP] |=> !st_q.cw[BIT_ACK])
		else $error("stop request not acknowledged");
	chk_select_ptr: assert property (accept |=> buf_sel_valid
		&& (buf_sel == $past(st_q.cw[BIT_PTR]))
		&& (buf_mode == tsbmc_decode($past(st_q.cw[2:0]))))
		else $error("wrong buffer selection");
	chk_no_toggle: assert property (done.valid && !st_q.live && !software_reset_cmd
		|=> $stable(st_q.cw[BIT_PTR]))
		else $error("pointer toggled while stopped");
	chk_toggle: assert property (done.valid && st_q.live && done.error_free
		&& !software_reset_cmd |=> st_q.cw[BIT_PTR] != $past(st_q.cw[BIT_PTR]))
		else $error("pointer not inverted");
	chk_host_ack_kept: assert property (host.wr && !cmd.valid && !done.valid
		&& !software_reset_cmd |=> $stable(st_q.cw[11:8]))
		else $error("host changed device bits");

	// A resume that is not cut short by a finish or a reset arms the toggle
	sequence s_pp_resume_clean;
		s_pp_resume ##0 (!done.valid && !software_reset_cmd);
	endsequence

	chk_resume_live: assert property (s_pp_resume_clean |=> st_q.live)
		else $error("resumed ping-pong not live");

	chk_sel_pulse: assert property (buf_sel_valid |-> $past(accept))
		else $error("selection without command");

	chk_err_no_toggle: assert property (done.valid && !done.error_free
		&& !software_reset_cmd |=> $stable(st_q.cw[BIT_PTR]))
		else $error("pointer toggled after error");

	// Without terminal enable a command with ping-pong on and no stop leaves the acknowledge at its last value
	chk_ack_hold_te: assert property (accept && st_q.cw[BIT_PINGPONG_ENABLE] && !st_q.cw[BIT_STOP]
		&& !terminal_enable |=> $stable(st_q.cw[BIT_ACK]))
		else $error("acknowledge moved without enable");

	chk_broadcast_received_flag_only: assert property (!accept && !software_reset_cmd
		|=> !$rose(st_q.cw[BIT_BROADCAST_RECEIVED_FLAG]))
		else $error("broadcast flag set without command");

	chk_disabled_quiet: assert property (cmd.valid && cmd.broadcast && broadcast_disable
		&& !software_reset_cmd |=> $stable(st_q.cw[BIT_BROADCAST_RECEIVED_FLAG]))
		else $error("disabled broadcast touched flag");

	chk_swrst_live: assert property (software_reset_cmd |=> !st_q.live)
		else $error("software reset left message live");

	chk_mode_hold: assert property (!accept
		|=> $stable(buf_mode) && $stable(buf_sel))
		else $error("selection changed without command");

	// Only an error-free finish of a live message or a software reset may move the pointer
	chk_ptr_owner: assert property (!done.valid && !software_reset_cmd
		|=> $stable(st_q.cw[BIT_PTR]))
		else $error("pointer changed without finish");

	chk_illegal_src: assert property (illegal_cmd
		|-> $past(accept) && $past(cmd.broadcast))
		else $error("illegal without broadcast");

	chk_rdata_read: assert property (host.rd
		|=> host_rdata == $past(st_q.cw))
		else $error("read data not the control word");

	chk_zn_follow: assert property (host.wr
		|=> circ2_trailing_zero_count == $past(host.wdata[ZN_MSB:ZN_LSB]))
		else $error("zero count not stored");
endmodule

// file: verilog/tsbmc_pkg.sv
// Package for the transmit subaddress buffer mode control word
package tsbmc_pkg;
	localparam int CW_WIDTH = 16;
	localparam logic [15:0] CW_RESET = 16'h0000;
	localparam int BIT_CIR1 = 0;
	localparam int BIT_CIR2 = 1;
	localparam int BIT_PINGPONG_ENABLE = 2;
	localparam int BIT_STOP = 3;
	localparam int ZN_LSB = 4;
	localparam int ZN_MSB = 7;
	localparam int BIT_ACK = 8;
	localparam int BIT_BROADCAST_RECEIVED_FLAG = 9;
	localparam int BIT_PTR = 10;
	// Host-writable bits: 7-0 and 15-12; bits 11-8 belong to the device
	localparam logic [15:0] HOST_WR_MASK = 16'hF0FF;

	typedef enum logic [1:0] {
		TSBMC_INDEXED,
		TSBMC_CIRC1,
		TSBMC_CIRC2,
		TSBMC_PINGPONG
	} tsbmc_mode_t;

	typedef struct packed {
		logic valid;
		logic broadcast;
	} tsbmc_cmd_t;

	typedef struct packed {
		logic valid;
		logic error_free;
	} tsbmc_done_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] wdata;
	} tsbmc_host_t;

	function automatic tsbmc_mode_t tsbmc_decode(input logic [2:0] bits);
		if (bits[2])
			return TSBMC_PINGPONG;
		else if (bits[1])
			return TSBMC_CIRC2;
		else if (bits[0])
			return TSBMC_CIRC1;
		else
			return TSBMC_INDEXED;
	endfunction
endpackage
